/* File: rtl/txirq_status_mask.sv */
// interrupt status and mask registers for two transmit stream engines
`timescale 1ns/1ns
module txirq_status_mask
   import txirq_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire txirq_wb_req_t wb_req,
   output logic [TXIRQ_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire txirq_events_t tx1_events,
   input wire txirq_events_t tx2_events,
   output logic irq
);
   // byte lanes of the bus word
   localparam int LANE_W = TXIRQ_ENGINE_STRIDE;
   localparam int LANES = TXIRQ_DW / LANE_W;
   // first bit above the engine bytes
   localparam int USED_W = TXIRQ_ENGINES * TXIRQ_ENGINE_STRIDE;

   // register state
   logic [TXIRQ_DW-1:0] status;
   logic [TXIRQ_DW-1:0] mask;

   // next values
   logic [TXIRQ_DW-1:0] next_status;
   logic [TXIRQ_DW-1:0] next_mask;
   logic [TXIRQ_DW-1:0] next_dat;
   logic next_ack;
   logic next_irq;

   // bus decode
   logic access;
   logic hit_status;
   logic hit_mask;
   logic wr_status;
   logic wr_mask;
   logic rd_status;
   logic rd_mask;
   logic [TXIRQ_DW-1:0] lane_mask;
   logic [TXIRQ_DW-1:0] clear_bits;
   logic [TXIRQ_DW-1:0] write_bits;
   logic [TXIRQ_DW-1:0] keep_bits;

   // event mapping
   logic [TXIRQ_DW-1:0] event_bits;
   txirq_events_t engine_ev [TXIRQ_ENGINES];

   // flags that may raise the interrupt
   logic [TXIRQ_DW-1:0] pending;

   assign engine_ev[0] = tx1_events;
   assign engine_ev[1] = tx2_events;

   // map each engine's event pulses onto its byte of the status word
   genvar g;
   generate
      for (g = 0; g < TXIRQ_ENGINES; g = g + 1) begin : g_engine
         localparam int B = g * TXIRQ_ENGINE_STRIDE;
         assign event_bits[B + TXIRQ_E1_ENDED] = engine_ev[g].ended;
         assign event_bits[B + TXIRQ_E1_STARTED] = engine_ev[g].started;
         assign event_bits[B + TXIRQ_E1_OVERFLOW] = engine_ev[g].overflow;
         assign event_bits[B + TXIRQ_E1_UNDERFLOW] = engine_ev[g].underflow;
         assign event_bits[B + TXIRQ_E1_BOUNDARY] = engine_ev[g].boundary;
         assign event_bits[B + TXIRQ_E1_STALE] = engine_ev[g].stale;
         assign event_bits[B + TXIRQ_E1_ABORT] = engine_ev[g].aborted;
         assign event_bits[B] = 1'b0;
      end
   endgenerate

   // reserved upper half never sees an event
   genvar r;
   generate
      for (r = USED_W; r < TXIRQ_DW; r = r + 1) begin : g_reserved
         assign event_bits[r] = 1'b0;
      end
   endgenerate

   // one select bit widened over each byte lane
   genvar l;
   generate
      for (l = 0; l < LANES; l = l + 1) begin : g_lane
         assign lane_mask[l * LANE_W +: LANE_W] = {LANE_W{wb_req.sel[l]}};
      end
   endgenerate

   // request decode, full address compare
   always_comb begin
      access = wb_req.cyc && wb_req.stb && !wb_ack_o;
      hit_status = 1'b0;
      hit_mask = 1'b0;
      if (wb_req.adr == TXIRQ_STATUS_ADDR) begin
         hit_status = 1'b1;
      end else if (wb_req.adr == TXIRQ_MASK_ADDR) begin
         hit_mask = 1'b1;
      end
      wr_status = access && hit_status && wb_req.we;
      wr_mask = access && hit_mask && wb_req.we;
      rd_status = access && hit_status && !wb_req.we;
      rd_mask = access && hit_mask && !wb_req.we;
      write_bits = wb_req.dat & lane_mask;
      keep_bits = ~lane_mask;
      clear_bits = TXIRQ_RESET_VALUE;
      if (wr_status) begin
         clear_bits = write_bits;
      end
   end

   // sticky flags, one per live bit; the other bits stay zero
   genvar i;
   generate
      for (i = 0; i < TXIRQ_DW; i = i + 1) begin : g_flag
         always_comb begin
            if (!TXIRQ_LIVE_BITS[i]) begin
               next_status[i] = 1'b0;
            end else if (event_bits[i]) begin
               // set wins over a clear in the same cycle
               next_status[i] = 1'b1;
            end else if (clear_bits[i]) begin
               next_status[i] = 1'b0;
            end else begin
               next_status[i] = status[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (reset) begin
         status <= TXIRQ_RESET_VALUE;
      end else begin
         status <= next_status;
      end
   end

   // mask, written lane by lane
   always_comb begin
      next_mask = mask;
      if (wr_mask) begin
         next_mask = (mask & keep_bits) | write_bits;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         mask <= TXIRQ_RESET_VALUE;
      end else begin
         mask <= next_mask;
      end
   end

   // bus answer: one ack per taken request, data only in the ack cycle
   always_comb begin
      next_ack = access;
      next_dat = TXIRQ_UNMAPPED_DATA;
      if (rd_status) begin
         next_dat = status;
      end else if (rd_mask) begin
         next_dat = mask;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= TXIRQ_RESET_VALUE;
      end else begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // interrupt from the values the registers are about to take
   always_comb begin
      pending = next_status & next_mask;
      next_irq = |pending;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end
endmodule

/* File: rtl/txirq_pkg.sv */
// package for the transmit stream interrupt status and mask block
package txirq_pkg;
   localparam int TXIRQ_DW = 32;
   localparam int TXIRQ_AW = 32;
   localparam logic [31:0] TXIRQ_STATUS_ADDR = 32'hCF000144;
   localparam logic [31:0] TXIRQ_MASK_ADDR = 32'hCF000148;
   localparam logic [31:0] TXIRQ_RESET_VALUE = 32'h00000000;
   localparam logic [31:0] TXIRQ_UNMAPPED_DATA = 32'h00000000;
   // bit positions of the event flags, engine one
   localparam int TXIRQ_E1_ABORT = 1;
   localparam int TXIRQ_E1_STALE = 2;
   localparam int TXIRQ_E1_BOUNDARY = 3;
   localparam int TXIRQ_E1_UNDERFLOW = 4;
   localparam int TXIRQ_E1_OVERFLOW = 5;
   localparam int TXIRQ_E1_STARTED = 6;
   localparam int TXIRQ_E1_ENDED = 7;
   // engine two sits one byte higher
   localparam int TXIRQ_ENGINE_STRIDE = 8;
   localparam int TXIRQ_ENGINES = 2;
   localparam int TXIRQ_EVENTS = 7;
   // bits that may ever be set: 15:9 and 7:1
   localparam logic [31:0] TXIRQ_LIVE_BITS = 32'h0000FEFE;

   typedef struct packed {
      logic ended;
      logic started;
      logic overflow;
      logic underflow;
      logic boundary;
      logic stale;
      logic aborted;
   } txirq_events_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [TXIRQ_AW-1:0] adr;
      logic [TXIRQ_DW-1:0] dat;
   } txirq_wb_req_t;
endpackage

/* File: sim/txirq_engines.sv */
// engine model raising event pulses
`timescale 1ns/1ns
module txirq_engines
   import txirq_pkg::*;
(
   input wire logic [15:0] fire,
   output txirq_events_t tx1_events,
   output txirq_events_t tx2_events
);
   assign tx1_events = fire[7:1];
   assign tx2_events = fire[15:9];
endmodule

/* File: sim/txirq_assertions.sv */
// checker for the status and mask block
`timescale 1ns/1ns
module txirq_chk
   import txirq_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic wb_ack_o,
   input wire logic irq,
   input wire txirq_wb_req_t wb_req,
   input wire logic [31:0] wb_dat_o,
   input wire txirq_events_t tx1_events,
   input wire txirq_events_t tx2_events
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   wire wr = wb_ack_o && wb_req.we;
   wire rd = wb_ack_o && !wb_req.we;
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   chk_ack_due: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   chk_ack_stray: assert property (!(wb_req.cyc && wb_req.stb) |=> !wb_ack_o) else $error("stray ack");
   chk_data_idle: assert property (!wb_ack_o |-> !wb_dat_o) else $error("stray data");
   chk_dead_bits: assert property (rd && wb_req.adr != TXIRQ_MASK_ADDR |-> !(wb_dat_o & ~TXIRQ_LIVE_BITS))
      else $error("dead bits");
   chk_unmapped_zero: assert property (rd && wb_req.adr[3:0] == 4'hC |-> !wb_dat_o) else $error("unmapped");
   chk_irq_fall: assert property ($fell(irq) |-> wr) else $error("irq fell");
   chk_irq_rise: assert property ($rose(irq) |-> wr || $past(tx1_events || tx2_events)) else $error("irq rose");
   cover property ($rose(irq));
   cover property ($fell(irq));
   cover property (wr);
endmodule
bind txirq_status_mask txirq_chk txirq_chk_inst (.*);

/* File: sim/txirq_status_mask_tb.sv */
// bench for the status and mask block
`timescale 1ns/1ns
module txirq_status_mask_tb import txirq_pkg::*; ;
   logic clock = 1'b0, reset = 1'b1, irq, wb_ack_o;
   logic [15:0] fire = 16'h0;
   logic [31:0] wb_dat_o;
   txirq_wb_req_t wb_req = '0;
   txirq_events_t tx1_events, tx2_events;
   int errors, checks_done;
   txirq_engines txirq_engines_inst (.*);
   txirq_status_mask txirq_status_mask_inst (.*);
   task automatic cmp(input logic [31:0] s, e);
      checks_done++;
      errors += int'(s !== e);
      if (s !== e) $display("ERROR %0t mismatch %h", $time, s);
   endtask
   task automatic wrap_up;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic acc(input logic we, input logic [31:0] a, d, input logic [3:0] sel = 4'hF);
      wb_req <= '{1'b1, 1'b1, we, sel, a, d};
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      if (!we) cmp(wb_dat_o, d);
      wb_req <= '0;
      @(posedge clock);
   endtask
   initial forever #25 clock = ~clock;
   initial begin
      #500000 errors++;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      acc(0, TXIRQ_MASK_ADDR, 32'h0);
      acc(0, TXIRQ_STATUS_ADDR, 32'h0);
      acc(0, 32'hCF00014C, 32'h0);
      for (int b = 0; b < 16; b++) begin
         fire <= 16'h1 << b;
         @(posedge clock);
         fire <= 16'h0;
         acc(0, TXIRQ_STATUS_ADDR, TXIRQ_LIVE_BITS & (32'h1 << b));
         cmp(32'(irq), 32'h0);
         acc(1, TXIRQ_MASK_ADDR, 32'h1 << b);
         cmp(32'(irq), 32'(TXIRQ_LIVE_BITS[b]));
         acc(1, TXIRQ_STATUS_ADDR, 32'h1 << b);
         cmp(32'(irq), 32'h0);
      end
      acc(0, TXIRQ_MASK_ADDR, 32'h8000);
      // all flags at once; reads leave them set
      fire <= 16'hFFFF;
      @(posedge clock);
      fire <= 16'h0;
      acc(0, TXIRQ_STATUS_ADDR, TXIRQ_LIVE_BITS);
      acc(0, TXIRQ_STATUS_ADDR, TXIRQ_LIVE_BITS);
      acc(1, TXIRQ_MASK_ADDR, 32'hFFFFFFFF);
      acc(0, TXIRQ_MASK_ADDR, 32'hFFFFFFFF);
      acc(1, TXIRQ_MASK_ADDR, 32'h0, 4'h3);
      acc(0, TXIRQ_MASK_ADDR, 32'hFFFF0000);
      cmp(32'(irq), 32'h0);
      acc(1, TXIRQ_STATUS_ADDR, 32'hFFFFFFFF, 4'h2);
      acc(0, TXIRQ_STATUS_ADDR, 32'h000000FE);
      acc(1, TXIRQ_MASK_ADDR, 32'h00000002);
      cmp(32'(irq), 32'h1);
      // event and clear in one cycle: set wins
      acc(1, TXIRQ_STATUS_ADDR, 32'h000000FF);
      acc(1, TXIRQ_MASK_ADDR, 32'h00000080);
      cmp(32'(irq), 32'h0);
      fire <= 16'h0080;
      fork
         begin
            @(posedge clock);
            fire <= 16'h0;
         end
      join_none
      acc(1, TXIRQ_STATUS_ADDR, 32'h00000080);
      acc(0, TXIRQ_STATUS_ADDR, 32'h00000080);
      cmp(32'(irq), 32'h1);
      acc(1, TXIRQ_STATUS_ADDR, 32'h00000080);
      acc(0, TXIRQ_STATUS_ADDR, 32'h0);
      cmp(32'(irq), 32'h0);
      // event under an open mask raises the interrupt
      acc(1, TXIRQ_MASK_ADDR, 32'h00008000);
      fire <= 16'h8000;
      @(posedge clock);
      fire <= 16'h0;
      @(posedge clock);
      cmp(32'(irq), 32'h1);
      // reset in mid-run
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      cmp(32'(irq), 32'h0);
      acc(0, TXIRQ_STATUS_ADDR, 32'h0);
      acc(0, TXIRQ_MASK_ADDR, 32'h0);
      wrap_up;
   end
endmodule
